// file: shared/sbus_pkg.sv
// Shared constants and types for the serial bus acknowledge, busy and address channel
`default_nettype none
package sbus_pkg;

	// Register select codes on the CPU register port
	localparam logic [1:0] SEL_BUS_CONTROL = 2'h0;
	localparam logic [1:0] SEL_SHIFT = 2'h1;
	localparam logic [1:0] SEL_SLAVE_ADDR = 2'h2;
	localparam logic [1:0] SEL_MODE = 2'h3;

	// Bus control register field positions
	localparam int BC_BUSY_EN = 0;
	localparam int BC_ACK_DET = 1;
	localparam int BC_AUTO_ACK = 2;
	localparam int BC_ACK_TRIG = 3;
	localparam int BC_CMD_DET = 4;
	localparam int BC_FREE_DET = 5;
	localparam int BC_ERROR = 6;

	// Serial mode register field positions
	localparam int MD_TRANSMIT = 0;
	localparam int MD_WAKE_UP = 5;
	localparam int MD_ADDR_MATCH = 6;
	localparam int MD_ENABLE = 7;

	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

	// Number of data bits per transfer
	localparam logic [3:0] BITS_PER_FRAME = 4'h8;

	// Synchroniser width for pin inputs, one bit per pin (clock and data)
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wdata;
	} cpu_req_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_NINTH,
		ST_DONE
	} xfer_state_t;

endpackage : sbus_pkg
`default_nettype wire

// file: core/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins in and synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1_r;

	// Pins idle high on an open-drain bus, so reset to released
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_r <= '1;
			sync_out <= '1;
		end else begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end
endmodule : pin_sync
`default_nettype wire

// file: core/sbus_channel.sv
// Serial bus channel: shift register, acknowledge, busy, condition detect and address compare
`timescale 1ns/10ps
`default_nettype none
module sbus_channel
	import sbus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// CPU register port
	input wire sbus_pkg::cpu_req_t cpu_req,
	output logic [7:0] cpu_rdata,
	// Serial clock line, driven by the bus master
	input wire logic serial_clock_line,
	// Open-drain data bus line
	input wire logic data_bus_line_in,
	output logic data_bus_line_out,
	output logic data_bus_line_oe,
	// Serial interrupt request
	output logic serial_interrupt_request
);
	import sbus_pkg::*;

	function automatic logic flag_update(input logic cur, input logic set, input logic clr);
		flag_update = set | (cur & ~clr);
	endfunction : flag_update

	logic [1:0] pins_sync;
	logic sck_r;
	logic sda_r;
	logic sck_s;
	logic sda_s;
	logic sck_rise;
	logic sck_fall;
	logic sda_rise;
	logic sda_fall;

	xfer_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_register;
	logic [7:0] slave_address_register;
	logic [7:0] serial_mode_register;
	logic busy_auto_enable;
	logic auto_acknowledge_enable;
	logic acknowledge_trigger;
	logic ack_pend_r;
	logic ack_drv_r;
	logic busy_drv_r;
	logic out_low_r;
	logic acknowledge_detect_flag;
	logic command_detect_flag;
	logic bus_free_detect_flag;
	logic error_flag_r;
	logic address_match_flag;
	logic irq_r;

	logic serial_enable_bit;
	logic wake_up_select;
	logic transmit_sel;
	logic wr_bc;
	logic wr_shift;
	logic wr_addr;
	logic wr_mode;
	logic xfer_start;
	logic last_bit;
	logic [7:0] shift_nxt;
	logic addr_match_nxt;

	pin_sync #(
		.W(SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in({serial_clock_line, data_bus_line_in}),
		.sync_out(pins_sync)
	);

	assign sck_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	// Delayed copies of the synchronised levels give the edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			sck_r <= sck_s;
			sda_r <= sda_s;
		end
	end

	assign sck_rise = sck_s & ~sck_r;
	assign sck_fall = ~sck_s & sck_r;
	assign sda_rise = sda_s & ~sda_r & sck_s & sck_r;
	assign sda_fall = ~sda_s & sda_r & sck_s & sck_r;

	assign serial_enable_bit = serial_mode_register[MD_ENABLE];
	assign wake_up_select = serial_mode_register[MD_WAKE_UP];
	assign transmit_sel = serial_mode_register[MD_TRANSMIT];

	// Register port decode
	always_comb begin
		wr_bc = 1'b0;
		wr_shift = 1'b0;
		wr_addr = 1'b0;
		wr_mode = 1'b0;
		if (cpu_req.wr && cpu_req.sel == SEL_BUS_CONTROL) begin
			wr_bc = 1'b1;
		end else if (cpu_req.wr && cpu_req.sel == SEL_SHIFT) begin
			wr_shift = 1'b1;
		end else if (cpu_req.wr && cpu_req.sel == SEL_SLAVE_ADDR) begin
			wr_addr = 1'b1;
		end else if (cpu_req.wr && cpu_req.sel == SEL_MODE) begin
			wr_mode = 1'b1;
		end
	end

	// A write with the channel disabled loads the register and clears the address match flag
	assign xfer_start = wr_shift & serial_enable_bit;
	assign last_bit = (bit_cnt_r == BITS_PER_FRAME - 4'h1);
	assign shift_nxt = {shift_register[6:0], sda_s};
	assign addr_match_nxt = (shift_nxt == slave_address_register);

	// Read mux; the slave address register is not readable
	always_comb begin
		cpu_rdata = 8'h00;
		if (cpu_req.rd && cpu_req.sel == SEL_BUS_CONTROL) begin
			cpu_rdata[BC_BUSY_EN] = busy_auto_enable;
			cpu_rdata[BC_ACK_DET] = acknowledge_detect_flag;
			cpu_rdata[BC_AUTO_ACK] = auto_acknowledge_enable;
			cpu_rdata[BC_ACK_TRIG] = acknowledge_trigger;
			cpu_rdata[BC_CMD_DET] = command_detect_flag;
			cpu_rdata[BC_FREE_DET] = bus_free_detect_flag;
			cpu_rdata[BC_ERROR] = error_flag_r;
		end else if (cpu_req.rd && cpu_req.sel == SEL_SHIFT) begin
			cpu_rdata = shift_register;
		end else if (cpu_req.rd && cpu_req.sel == SEL_MODE) begin
			cpu_rdata = serial_mode_register;
			cpu_rdata[MD_ADDR_MATCH] = address_match_flag;
		end
	end

	// Data registers have no reset so their contents survive it
	always_ff @(posedge clk) begin
		if (wr_addr) begin
			slave_address_register <= cpu_req.wdata;
		end
		if (wr_shift) begin
			shift_register <= cpu_req.wdata;
		end else if (state_r == ST_SHIFT && sck_rise) begin
			shift_register <= shift_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_mode_register <= MODE_RESET;
			busy_auto_enable <= 1'b0;
			auto_acknowledge_enable <= 1'b0;
		end else begin
			if (wr_mode) begin
				serial_mode_register <= cpu_req.wdata;
			end
			if (wr_bc) begin
				busy_auto_enable <= cpu_req.wdata[BC_BUSY_EN];
				auto_acknowledge_enable <= cpu_req.wdata[BC_AUTO_ACK];
			end
		end
	end

	// Transfer sequencing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= BIT_COUNT_RESET;
		end else if (!serial_enable_bit) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= BIT_COUNT_RESET;
		end else if (xfer_start) begin
			state_r <= ST_SHIFT;
			bit_cnt_r <= BIT_COUNT_RESET;
		end else begin
			case (state_r)
				ST_SHIFT: begin
					if (sck_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						if (last_bit) begin
							state_r <= ST_NINTH;
						end
					end
				end
				ST_NINTH: begin
					if (sck_rise) begin
						state_r <= ST_DONE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Transmit bit changes only while the clock is low, never as a false condition
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_low_r <= 1'b0;
		end else if (!serial_enable_bit || xfer_start) begin
			out_low_r <= 1'b0;
		end else if (sck_fall) begin
			out_low_r <= (state_r == ST_SHIFT) & transmit_sel & ~shift_register[7];
		end
	end

	// Acknowledge pending: trigger, or auto enable raised after the transfer ended
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_pend_r <= 1'b0;
		end else if (!serial_enable_bit || xfer_start) begin
			ack_pend_r <= 1'b0;
		end else if (wr_bc && cpu_req.wdata[BC_ACK_TRIG]) begin
			ack_pend_r <= 1'b1;
		end else if (wr_bc && cpu_req.wdata[BC_AUTO_ACK] && !auto_acknowledge_enable && state_r == ST_DONE) begin
			ack_pend_r <= 1'b1;
		end else if (sck_fall && !ack_drv_r && (state_r == ST_DONE || state_r == ST_NINTH)) begin
			ack_pend_r <= 1'b0;
		end
	end

	// Trigger is set only by software and cleared only when its acknowledge ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acknowledge_trigger <= 1'b0;
		end else begin
			acknowledge_trigger <= flag_update(acknowledge_trigger, wr_bc && cpu_req.wdata[BC_ACK_TRIG],
				sck_fall && ack_drv_r);
		end
	end

	// Acknowledge low for one full clock period, falling edge to falling edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_drv_r <= 1'b0;
		end else if (!serial_enable_bit || xfer_start) begin
			ack_drv_r <= 1'b0;
		end else if (sck_fall) begin
			if (ack_drv_r) begin
				ack_drv_r <= 1'b0;
			end else if (state_r == ST_NINTH) begin
				ack_drv_r <= auto_acknowledge_enable | ack_pend_r;
			end else if (state_r == ST_DONE) begin
				ack_drv_r <= ack_pend_r;
			end
		end
	end

	// Busy follows the acknowledge; a new transfer start returns the line to ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_drv_r <= 1'b0;
		end else if (!serial_enable_bit || xfer_start) begin
			busy_drv_r <= 1'b0;
		end else if (sck_fall) begin
			if (!busy_auto_enable) begin
				busy_drv_r <= 1'b0;
			end else if (ack_drv_r) begin
				busy_drv_r <= 1'b1;
			end
		end
	end

	// Acknowledge detect, and error on a released transmit bit read back low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acknowledge_detect_flag <= 1'b0;
			error_flag_r <= 1'b0;
		end else begin
			acknowledge_detect_flag <= flag_update(acknowledge_detect_flag,
				sck_rise && !sda_s && (state_r == ST_NINTH || ack_drv_r), xfer_start);
			error_flag_r <= flag_update(error_flag_r,
				sck_rise && state_r == ST_SHIFT && transmit_sel && shift_register[7] && !sda_s,
				xfer_start);
		end
	end

	// Bus condition flags; a detection in the clearing cycle wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			command_detect_flag <= 1'b0;
			bus_free_detect_flag <= 1'b0;
		end else if (!serial_enable_bit) begin
			command_detect_flag <= 1'b0;
			bus_free_detect_flag <= 1'b0;
		end else begin
			command_detect_flag <= flag_update(command_detect_flag, sda_fall, xfer_start | sda_rise);
			bus_free_detect_flag <= flag_update(bus_free_detect_flag, sda_rise,
				xfer_start | (state_r == ST_SHIFT && sck_rise && last_bit && !addr_match_nxt));
		end
	end

	// Address compare result, valid once the eighth bit is in
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			address_match_flag <= 1'b0;
		end else if (state_r == ST_SHIFT && sck_rise && last_bit) begin
			address_match_flag <= addr_match_nxt;
		end else if (wr_addr || (wr_shift && !serial_enable_bit)) begin
			address_match_flag <= 1'b0;
		end
	end

	// Request at the ninth rising edge; with wake-up only on a matched address after bus free
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= serial_enable_bit && state_r == ST_NINTH && sck_rise &&
				(!wake_up_select || (address_match_flag && bus_free_detect_flag));
		end
	end

	assign serial_interrupt_request = irq_r;

	// Open drain: only ever pull low, otherwise release
	assign data_bus_line_out = 1'b0;
	assign data_bus_line_oe = serial_enable_bit & (ack_drv_r | busy_drv_r | out_low_r);

endmodule : sbus_channel
`default_nettype wire

// file: tb/sbus_master_model.sv
// Bus master model: serial clock and open-drain pull-down on the data wire
`timescale 1ns/10ps
`default_nettype none
module sbus_master_model (
	// Resolved data wire
	input wire logic sda,
	// Clock and pull-down drive
	output logic sck,
	output logic pull
);
	real half = 62.5;
	initial begin
		sck = 1'b1;
		pull = 1'b0;
	end
	// Conditions without a clock pulse, so no bit is counted
	task start_addr();
		#20 pull = 1'b1;
		#40 pull = 1'b0;
		#40 pull = 1'b1;
		#40;
	endtask : start_addr
	// Data changes only while the clock is low
	task xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			#20 pull = ~tx[i];
			#(half - 20) sck = 1'b1;
			#30 rx[i] = sda;
			#(half - 30);
		end
		sck = 1'b0;
		#20 pull = 1'b0;
		#(half - 20) sck = 1'b1;
		#30 ack = ~sda;
		#(half - 30);
	endtask : xfer
	// One extra clock, sampling the wire late in the low phase
	task pulse(output logic lvl);
		sck = 1'b0;
		#(half) lvl = sda;
		sck = 1'b1;
		#(half);
	endtask : pulse
endmodule : sbus_master_model
`default_nettype wire

// file: tb/sbus_channel_chk.sv
// Port checker for the serial bus channel
`timescale 1ns/10ps
`default_nettype none
module sbus_channel_chk
	import sbus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire sbus_pkg::cpu_req_t cpu_req,
	input wire logic [7:0] cpu_rdata,
	// Serial pins
	input wire logic serial_clock_line,
	input wire logic data_bus_line_in,
	input wire logic data_bus_line_out,
	input wire logic data_bus_line_oe,
	input wire logic serial_interrupt_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pin_never_high: assert property (data_bus_line_out == 1'b0)
		else $error("data pin driven high");
	a_wire_follows_oe: assert property (data_bus_line_oe |-> !data_bus_line_in)
		else $error("wire high while pulled");
	a_irq_one_cycle: assert property (serial_interrupt_request |=> !serial_interrupt_request)
		else $error("request longer than a cycle");
	a_irq_on_rise: assert property (serial_interrupt_request |-> serial_clock_line && !$past(serial_clock_line, 6))
		else $error("request not at a rising clock");
	a_addr_reads_zero: assert property (cpu_req.rd && cpu_req.sel == SEL_SLAVE_ADDR |-> cpu_rdata == 8'h00)
		else $error("slave address readable");
	a_drive_at_fall: assert property ($rose(data_bus_line_oe) && !$past(cpu_req.wr) |-> !serial_clock_line)
		else $error("drive began with clock high");
	a_release_at_fall: assert property ($fell(data_bus_line_oe) && !$past(cpu_req.wr) |-> !serial_clock_line)
		else $error("drive ended with clock high");
	a_trig_no_clear: assert property (cpu_req.wr && cpu_req.rd && cpu_req.sel == SEL_BUS_CONTROL
		&& !cpu_req.wdata[BC_ACK_TRIG] && cpu_rdata[BC_ACK_TRIG] && serial_clock_line
		&& $past(serial_clock_line, 4) |=> !cpu_req.rd || cpu_rdata[BC_ACK_TRIG])
		else $error("trigger cleared by a write");
endmodule : sbus_channel_chk
bind sbus_channel sbus_channel_chk i_sbus_channel_chk(.clk(clk), .rst(rst), .cpu_req(cpu_req),
	.cpu_rdata(cpu_rdata), .serial_clock_line(serial_clock_line), .data_bus_line_in(data_bus_line_in),
	.data_bus_line_out(data_bus_line_out), .data_bus_line_oe(data_bus_line_oe),
	.serial_interrupt_request(serial_interrupt_request));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial bus channel
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sbus_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	cpu_req_t req = '0;
	logic [7:0] rdata, rx, slave_address;
	logic sck, pull, oe, dout, irq, sda, ack, lvl;
	logic [31:0] seed = 32'h5389;
	int failures = 0;
	int compares = 0;
	int irqs = 0;
	int m_irqs = 0;
	int cyc = 0;
	// Pull-up on the open-drain wire
	assign sda = ~(pull | oe);
	always #2 clk = ~clk;
	sbus_channel i_sbus_channel(.clk(clk), .rst(rst), .cpu_req(req), .cpu_rdata(rdata),
		.serial_clock_line(sck), .data_bus_line_in(sda), .data_bus_line_out(dout),
		.data_bus_line_oe(oe), .serial_interrupt_request(irq));
	sbus_master_model i_sbus_master_model(.sda(sda), .sck(sck), .pull(pull));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function logic [7:0] b(input int i);
		return 8'h01 << i;
	endfunction : b
	task test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	// Read stays asserted one cycle past the write strobe
	task wr(input logic [1:0] s, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b1, sel: s, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
		req = '0;
	endtask : wr
	task rc(input string n, input logic [1:0] s, input logic [7:0] m, input logic [7:0] e);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
		#1 check(n, rdata & m, e);
		@(negedge clk);
		req = '0;
	endtask : rc
	always @(posedge clk) begin
		cyc++;
		if (irq === 1'b1) irqs++;
		if (cyc == 30000) begin
			failures++;
			test_done();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		rc("control reset", SEL_BUS_CONTROL, 8'hFF, 8'h00);
		rc("mode reset", SEL_MODE, 8'hFF, MODE_RESET);
		wr(SEL_BUS_CONTROL, 8'hF4);
		rc("control fields", SEL_BUS_CONTROL, 8'hFF, 8'h04);
		seed = lfsr(seed);
		slave_address = seed[7:0];
		wr(SEL_SLAVE_ADDR, slave_address);
		rc("address read", SEL_SLAVE_ADDR, 8'hFF, 8'h00);
		wr(SEL_MODE, 8'hA0);
		// Wake-up on: matching address, then a mismatch with a slow master
		for (int k = 0; k < 2; k++) begin
			i_sbus_master_model.half = k ? 150.0 : 62.5;
			wr(SEL_SHIFT, 8'hFF);
			i_sbus_master_model.start_addr();
			i_sbus_master_model.xfer(slave_address ^ 8'(k), rx, ack);
			if (k == 0) begin
				m_irqs++;
			end
			check("auto ack", {7'h0, ack}, 8'h01);
			rc("received", SEL_SHIFT, 8'hFF, slave_address ^ 8'(k));
			rc("match", SEL_MODE, b(MD_ADDR_MATCH), k ? 8'h00 : b(MD_ADDR_MATCH));
			rc("flags", SEL_BUS_CONTROL, 8'h72, b(BC_ACK_DET) | b(BC_CMD_DET) | (k ? 8'h00 : b(BC_FREE_DET)));
			check("irqs", 8'(irqs), 8'(m_irqs));
			i_sbus_master_model.pulse(lvl);
			check("ack length", {7'h0, lvl}, 8'h01);
		end
		i_sbus_master_model.half = 62.5;
		wr(SEL_BUS_CONTROL, 8'h00);
		wr(SEL_MODE, 8'h80);
		wr(SEL_SHIFT, 8'hFF);
		seed = lfsr(seed);
		i_sbus_master_model.xfer(seed[7:0], rx, ack);
		m_irqs++;
		check("no auto ack", {7'h0, ack}, 8'h00);
		wr(SEL_BUS_CONTROL, 8'h08);
		wr(SEL_BUS_CONTROL, 8'h01);
		rc("trigger held", SEL_BUS_CONTROL, b(BC_ACK_TRIG), b(BC_ACK_TRIG));
		i_sbus_master_model.pulse(lvl);
		check("triggered ack", {7'h0, lvl}, 8'h00);
		i_sbus_master_model.pulse(lvl);
		check("busy", {7'h0, lvl}, 8'h00);
		wr(SEL_BUS_CONTROL, 8'h00);
		i_sbus_master_model.pulse(lvl);
		check("busy off", {7'h0, lvl}, 8'h01);
		rc("trigger cleared", SEL_BUS_CONTROL, b(BC_ACK_TRIG), 8'h00);
		rc("shift stopped", SEL_SHIFT, 8'hFF, seed[7:0]);
		// Transmit: clean byte, then the master holds the wire low
		wr(SEL_MODE, 8'h81);
		for (int k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			wr(SEL_SHIFT, seed[7:0] | 8'h01);
			i_sbus_master_model.xfer(k ? 8'h00 : 8'hFF, rx, ack);
			m_irqs++;
			check("sent", rx, k ? 8'h00 : seed[7:0] | 8'h01);
			rc("error", SEL_BUS_CONTROL, b(BC_ERROR), k ? b(BC_ERROR) : 8'h00);
		end
		wr(SEL_BUS_CONTROL, 8'h04);
		i_sbus_master_model.pulse(lvl);
		check("late ack", {7'h0, lvl}, 8'h00);
		check("irqs", 8'(irqs), 8'(m_irqs));
		// Reset in standby must keep the shift register contents
		wr(SEL_MODE, 8'h00);
		wr(SEL_SHIFT, slave_address);
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rc("kept over reset", SEL_SHIFT, 8'hFF, slave_address);
		rc("control after reset", SEL_BUS_CONTROL, 8'hFF, 8'h00);
		test_done();
	end
endmodule : testbench
`default_nettype wire
